// ==== pdc_top.sv ====
// Loop divider control bank: buffered registers, decoders and R/A/B counters
`timescale 1ns/100ps
module pdc_top (
	// Clock and reset
	input  wire logic                          REF_CLK_IN,
	input  wire logic                          RESET_N_IN,
	// Register port
	input  wire logic                          REG_WR_IN,
	input  wire logic                          REG_RD_IN,
	input  wire logic [9:0]                    REG_ADDR_IN,
	input  wire logic [7:0]                    REG_WDATA_IN,
	output logic      [7:0]                    REG_RDATA_OUT,
	output logic                               REG_RVALID_OUT,
	// Divider input events
	input  wire logic                          REF_EDGE_IN,
	input  wire logic                          PRESC_EDGE_IN,
	// Phase detector
	input  wire logic                          DET_UP_IN,
	input  wire logic                          DET_DN_IN,
	// Charge pump control
	output logic                               PUMP_SOURCE_OUT,
	output logic                               PUMP_SINK_OUT,
	output logic                               PUMP_DRIVE_OUT,
	output logic                               PUMP_MID_SUPPLY_OUT,
	output logic      [2:0]                    PUMP_CURRENT_CODE_OUT,
	output logic      [12:0]                   PUMP_CURRENT_UA_OUT,
	output logic                               POLARITY_INV_OUT,
	// Power-down
	output logic                               PD_ASYNC_OUT,
	output logic                               PD_SYNC_OUT,
	// Divider outputs
	output logic                               R_DIV_OUT,
	output logic                               N_DIV_OUT,
	output logic                               MODULUS_HIGH_OUT,
	output logic      [2:0]                    PRESC_SEL_OUT,
	output logic                               B_BYPASS_OUT
);
	import pdc_pkg::*;

	//////////////////////////////////////////////////////////////////////////
	// Buffer and active register copies

	logic [7:0] buf_ff [7];
	logic [7:0] act_ff [7];
	logic [7:0] nxt_buf [7];
	logic [7:0] nxt_act [7];
	logic       rb_active_ff;
	logic       nxt_rb_active;
	logic [7:0] rdata_ff;
	logic [7:0] nxt_rdata;
	logic       rvalid_ff;
	logic       nxt_rvalid;
	logic [7:0] rst_val [7];
	logic       wr_hit;
	logic [2:0] wr_idx;
	logic       rd_hit;
	logic [2:0] rd_idx;
	logic       update;

	assign rst_val[0] = PDC_RST_LOOP_PUMP;
	assign rst_val[1] = PDC_RST_REF_LOW;
	assign rst_val[2] = PDC_RST_REF_HIGH;
	assign rst_val[3] = PDC_RST_A_COUNT;
	assign rst_val[4] = PDC_RST_B_LOW;
	assign rst_val[5] = PDC_RST_B_HIGH;
	assign rst_val[6] = PDC_RST_CNT_RESET;

	assign wr_hit = (REG_ADDR_IN >= PDC_ADDR_LOOP_PUMP) && (REG_ADDR_IN <= PDC_ADDR_CNT_RESET);
	assign wr_idx = 3'(REG_ADDR_IN - PDC_ADDR_LOOP_PUMP);
	assign rd_hit = wr_hit;
	assign rd_idx = wr_idx;
	// Update bit self-clears: it is never stored, only acted on
	assign update = REG_WR_IN && (REG_ADDR_IN == PDC_ADDR_UPDATE) && REG_WDATA_IN[PDC_BIT_UPDATE];

	always_comb begin
		nxt_rb_active = rb_active_ff;
		nxt_rvalid    = REG_RD_IN;
		nxt_rdata     = 8'h00;
		for (int i = 0; i < 7; i++) begin
			nxt_buf[i] = buf_ff[i];
			nxt_act[i] = update ? buf_ff[i] : act_ff[i];
		end
		if (REG_WR_IN && wr_hit) begin
			nxt_buf[wr_idx] = REG_WDATA_IN;
		end else if (REG_WR_IN && (REG_ADDR_IN == PDC_ADDR_READBACK_SEL)) begin
			nxt_rb_active = REG_WDATA_IN[PDC_BIT_RB_ACTIVE];
		end
		if (REG_RD_IN) begin
			if (rd_hit) begin
				nxt_rdata = rb_active_ff ? act_ff[rd_idx] : buf_ff[rd_idx];
			end else if (REG_ADDR_IN == PDC_ADDR_READBACK_SEL) begin
				nxt_rdata = {7'h00, rb_active_ff};
			end else begin
				nxt_rdata = 8'h00;
			end
		end
	end

	always_ff @(posedge REF_CLK_IN) begin
		if (!RESET_N_IN) begin
			for (int i = 0; i < 7; i++) begin
				buf_ff[i] <= rst_val[i];
				act_ff[i] <= rst_val[i];
			end
			rb_active_ff <= 1'b0;
			rdata_ff     <= 8'h00;
			rvalid_ff    <= 1'b0;
		end else begin
			for (int i = 0; i < 7; i++) begin
				buf_ff[i] <= nxt_buf[i];
				act_ff[i] <= nxt_act[i];
			end
			rb_active_ff <= nxt_rb_active;
			rdata_ff     <= nxt_rdata;
			rvalid_ff    <= nxt_rvalid;
		end
	end

	assign REG_RDATA_OUT  = rdata_ff;
	assign REG_RVALID_OUT = rvalid_ff;

	//////////////////////////////////////////////////////////////////////////
	// Active field extraction

	logic                  pol_inv;
	logic [2:0]            cur_code;
	logic [1:0]            pump_mode;
	logic [1:0]            pd_mode;
	logic [PDC_R_BITS-1:0] r_ratio;
	logic [PDC_A_BITS-1:0] a_val;
	logic [PDC_B_BITS-1:0] b_val;
	logic                  mid_supply;
	logic                  hold_r;
	logic                  hold_ab;
	logic                  bypass;

	assign pol_inv    = act_ff[0][PDC_BIT_POLARITY];
	assign cur_code   = act_ff[0][PDC_CUR_HI:PDC_CUR_LO];
	assign pump_mode  = act_ff[0][PDC_MODE_HI:PDC_MODE_LO];
	assign pd_mode    = act_ff[0][PDC_PD_HI:PDC_PD_LO];
	assign r_ratio    = {act_ff[2][5:0], act_ff[1]};
	assign a_val      = act_ff[3][5:0];
	assign b_val      = {act_ff[5][4:0], act_ff[4]};
	assign mid_supply = act_ff[6][PDC_BIT_MID_SUPPLY];
	assign hold_r     = act_ff[6][PDC_BIT_RST_REF] || act_ff[6][PDC_BIT_RST_ALL];
	assign hold_ab    = act_ff[6][PDC_BIT_RST_FB] || act_ff[6][PDC_BIT_RST_ALL];
	// Bypass only meaningful with prescaler in fixed-divide mode
	assign bypass     = act_ff[6][PDC_BIT_BYPASS];

	//////////////////////////////////////////////////////////////////////////
	// Pump and power-down decode

	logic        src_ff;
	logic        snk_ff;
	logic        drive_ff;
	logic [12:0] ua_ff;
	logic        nxt_src;
	logic        nxt_snk;
	logic        nxt_drive;
	logic [12:0] nxt_ua;
	logic        det_up;
	logic        det_dn;

	// Inverted sense swaps the detector outputs
	assign det_up = pol_inv ? DET_DN_IN : DET_UP_IN;
	assign det_dn = pol_inv ? DET_UP_IN : DET_DN_IN;

	always_comb begin
		nxt_ua    = 13'(PDC_PUMP_STEP_UA * ({10'h000, cur_code} + 13'h0001));
		nxt_src   = 1'b0;
		nxt_snk   = 1'b0;
		nxt_drive = 1'b0;
		case (pump_mode)
			PDC_MODE_TRISTATE: begin
				nxt_drive = 1'b0;
			end
			PDC_MODE_FORCE_UP: begin
				nxt_src   = 1'b1;
				nxt_drive = 1'b1;
			end
			PDC_MODE_FORCE_DN: begin
				nxt_snk   = 1'b1;
				nxt_drive = 1'b1;
			end
			default: begin
				nxt_src   = det_up;
				nxt_snk   = det_dn;
				nxt_drive = 1'b1;
			end
		endcase
		// Mid-supply overrides pumping entirely
		if (mid_supply) begin
			nxt_src   = 1'b0;
			nxt_snk   = 1'b0;
			nxt_drive = 1'b0;
		end
	end

	always_ff @(posedge REF_CLK_IN) begin
		if (!RESET_N_IN) begin
			src_ff   <= 1'b0;
			snk_ff   <= 1'b0;
			drive_ff <= 1'b0;
			ua_ff    <= 13'h0000;
		end else begin
			src_ff   <= nxt_src;
			snk_ff   <= nxt_snk;
			drive_ff <= nxt_drive;
			ua_ff    <= nxt_ua;
		end
	end

	assign PUMP_SOURCE_OUT       = src_ff;
	assign PUMP_SINK_OUT         = snk_ff;
	assign PUMP_DRIVE_OUT        = drive_ff;
	assign PUMP_CURRENT_UA_OUT   = ua_ff;
	assign PUMP_CURRENT_CODE_OUT = cur_code;
	assign PUMP_MID_SUPPLY_OUT   = mid_supply;
	assign POLARITY_INV_OUT      = pol_inv;
	assign PD_ASYNC_OUT          = (pd_mode == PDC_PD_ASYNC);
	assign PD_SYNC_OUT           = (pd_mode == PDC_PD_SYNC);
	assign PRESC_SEL_OUT         = act_ff[6][2:0];
	assign B_BYPASS_OUT          = bypass;

	//////////////////////////////////////////////////////////////////////////
	// Reference, A and B counters

	logic [PDC_R_BITS-1:0] r_cnt_ff;
	logic [PDC_R_BITS-1:0] nxt_r_cnt;
	logic [PDC_B_BITS-1:0] b_cnt_ff;
	logic [PDC_B_BITS-1:0] nxt_b_cnt;
	logic                  r_pulse_ff;
	logic                  nxt_r_pulse;
	logic                  n_pulse_ff;
	logic                  nxt_n_pulse;
	logic                  mod_ff;
	logic                  nxt_mod;
	logic [PDC_R_BITS-1:0] r_last;
	logic [PDC_B_BITS-1:0] b_last;

	// Ratio of zero treated as one
	assign r_last = (r_ratio == '0) ? '0 : r_ratio - 1'b1;
	assign b_last = (bypass || b_val == '0) ? '0 : b_val - 1'b1;

	always_comb begin
		nxt_r_cnt   = r_cnt_ff;
		nxt_r_pulse = 1'b0;
		nxt_b_cnt   = b_cnt_ff;
		nxt_n_pulse = 1'b0;
		if (hold_r) begin
			nxt_r_cnt = '0;
		end else if (REF_EDGE_IN) begin
			if (r_cnt_ff >= r_last) begin
				nxt_r_cnt   = '0;
				nxt_r_pulse = 1'b1;
			end else begin
				nxt_r_cnt = r_cnt_ff + 1'b1;
			end
		end
		if (hold_ab) begin
			nxt_b_cnt = '0;
		end else if (PRESC_EDGE_IN) begin
			if (b_cnt_ff >= b_last) begin
				nxt_b_cnt   = '0;
				nxt_n_pulse = 1'b1;
			end else begin
				nxt_b_cnt = b_cnt_ff + 1'b1;
			end
		end
		// Prescaler takes high modulus for first A cycles of each B period
		nxt_mod = !hold_ab && !bypass && ({7'h00, a_val} > nxt_b_cnt);
	end

	always_ff @(posedge REF_CLK_IN) begin
		if (!RESET_N_IN) begin
			r_cnt_ff   <= '0;
			b_cnt_ff   <= '0;
			r_pulse_ff <= 1'b0;
			n_pulse_ff <= 1'b0;
			mod_ff     <= 1'b0;
		end else begin
			r_cnt_ff   <= nxt_r_cnt;
			b_cnt_ff   <= nxt_b_cnt;
			r_pulse_ff <= nxt_r_pulse;
			n_pulse_ff <= nxt_n_pulse;
			mod_ff     <= nxt_mod;
		end
	end

	assign R_DIV_OUT        = r_pulse_ff;
	assign N_DIV_OUT        = n_pulse_ff;
	assign MODULUS_HIGH_OUT = mod_ff;

endmodule : pdc_top

// ==== pdc_pkg.sv ====
// Constants, register map and field layout for the loop divider control bank
//////////////////////////////////////////////////////////////////////////////
// What this block does
// - Polarity bit one inverts detector up/down sense
// - Pump current code maps to microamp magnitude
// - Pump mode: tristate, force up, down, normal
// - Power-down: normal, async, normal, sync
// - Fourteen-bit reference ratio split across two registers
// - Six-bit A counter, resets to zero
// - Thirteen-bit B counter split, resets to three
// - Mid-supply bit parks pump output at half
// - Reference reset bit holds reference counter cleared
// - Feedback reset bit holds A and B
// - Global reset bit holds all three counters
// - Bypass makes B divide by one
// - Writes land in buffer; select chooses readback copy
//////////////////////////////////////////////////////////////////////////////
package pdc_pkg;

	// Register offsets
	localparam logic [9:0] PDC_ADDR_READBACK_SEL = 10'h004;
	localparam logic [9:0] PDC_ADDR_LOOP_PUMP    = 10'h010;
	localparam logic [9:0] PDC_ADDR_REF_LOW      = 10'h011;
	localparam logic [9:0] PDC_ADDR_REF_HIGH     = 10'h012;
	localparam logic [9:0] PDC_ADDR_A_COUNT      = 10'h013;
	localparam logic [9:0] PDC_ADDR_B_LOW        = 10'h014;
	localparam logic [9:0] PDC_ADDR_B_HIGH       = 10'h015;
	localparam logic [9:0] PDC_ADDR_CNT_RESET    = 10'h016;
	localparam logic [9:0] PDC_ADDR_UPDATE       = 10'h232;

	// Reset values
	localparam logic [7:0] PDC_RST_LOOP_PUMP = 8'h7D;
	localparam logic [7:0] PDC_RST_REF_LOW   = 8'h01;
	localparam logic [7:0] PDC_RST_REF_HIGH  = 8'h00;
	localparam logic [7:0] PDC_RST_A_COUNT   = 8'h00;
	localparam logic [7:0] PDC_RST_B_LOW     = 8'h03;
	localparam logic [7:0] PDC_RST_B_HIGH    = 8'h00;
	localparam logic [7:0] PDC_RST_CNT_RESET = 8'h06;

	// Field positions
	localparam int PDC_BIT_POLARITY   = 7;
	localparam int PDC_CUR_HI         = 6;
	localparam int PDC_CUR_LO         = 4;
	localparam int PDC_MODE_HI        = 3;
	localparam int PDC_MODE_LO        = 2;
	localparam int PDC_PD_HI          = 1;
	localparam int PDC_PD_LO          = 0;
	localparam int PDC_BIT_MID_SUPPLY = 7;
	localparam int PDC_BIT_RST_REF    = 6;
	localparam int PDC_BIT_RST_FB     = 5;
	localparam int PDC_BIT_RST_ALL    = 4;
	localparam int PDC_BIT_BYPASS     = 3;
	localparam int PDC_BIT_UPDATE     = 0;
	localparam int PDC_BIT_RB_ACTIVE  = 0;

	// Divider widths
	localparam int PDC_R_BITS = 14;
	localparam int PDC_A_BITS = 6;
	localparam int PDC_B_BITS = 13;

	// Pump current: microamps per code step, nominal set resistor
	localparam logic [12:0] PDC_PUMP_STEP_UA = 13'h0258;

	// Pump mode encodings
	localparam logic [1:0] PDC_MODE_TRISTATE = 2'h0;
	localparam logic [1:0] PDC_MODE_FORCE_UP = 2'h1;
	localparam logic [1:0] PDC_MODE_FORCE_DN = 2'h2;
	localparam logic [1:0] PDC_MODE_NORMAL   = 2'h3;

	// Power-down encodings
	localparam logic [1:0] PDC_PD_ASYNC = 2'h1;
	localparam logic [1:0] PDC_PD_SYNC  = 2'h3;

endpackage : pdc_pkg

// ==== pdc_top_asserts.sv ====
// Port checker for the loop divider control bank
`timescale 1ns/100ps
module pdc_top_asserts (
	// Clock and reset
	input wire logic        REF_CLK_IN,
	input wire logic        RESET_N_IN,
	// Watched ports
	input wire logic        REG_RD_IN,
	input wire logic        REG_RVALID_OUT,
	input wire logic        REF_EDGE_IN,
	input wire logic        PRESC_EDGE_IN,
	input wire logic        PUMP_SOURCE_OUT,
	input wire logic        PUMP_SINK_OUT,
	input wire logic        PUMP_DRIVE_OUT,
	input wire logic        PUMP_MID_SUPPLY_OUT,
	input wire logic [2:0]  PUMP_CURRENT_CODE_OUT,
	input wire logic [12:0] PUMP_CURRENT_UA_OUT,
	input wire logic        PD_ASYNC_OUT,
	input wire logic        PD_SYNC_OUT,
	input wire logic        R_DIV_OUT,
	input wire logic        N_DIV_OUT,
	input wire logic        MODULUS_HIGH_OUT,
	input wire logic        B_BYPASS_OUT
);
	default clocking cb @(posedge REF_CLK_IN); endclocking
	default disable iff (!RESET_N_IN);
	chk_read_answer: assert property (REG_RD_IN |=> REG_RVALID_OUT)
		else $error("read not answered next cycle");
	chk_answer_cause: assert property (REG_RVALID_OUT |-> $past(REG_RD_IN))
		else $error("read answer without request");
	chk_current_scale: assert property ($past(RESET_N_IN) |->
		PUMP_CURRENT_UA_OUT == 13'(($past(PUMP_CURRENT_CODE_OUT) + 13'h1) * 13'h258))
		else $error("pump current magnitude wrong");
	chk_pd_exclusive: assert property (!(PD_ASYNC_OUT && PD_SYNC_OUT))
		else $error("both power-down kinds active");
	chk_pump_drive: assert property ((PUMP_SOURCE_OUT || PUMP_SINK_OUT) |-> PUMP_DRIVE_OUT)
		else $error("pump current without drive");
	chk_mid_parks: assert property (PUMP_MID_SUPPLY_OUT && $past(PUMP_MID_SUPPLY_OUT) && $past(RESET_N_IN)
		|-> !PUMP_DRIVE_OUT && !PUMP_SOURCE_OUT && !PUMP_SINK_OUT)
		else $error("pump driven while parked");
	chk_r_pulse_cause: assert property (R_DIV_OUT |-> $past(REF_EDGE_IN))
		else $error("reference pulse without edge");
	chk_n_pulse_cause: assert property (N_DIV_OUT |-> $past(PRESC_EDGE_IN))
		else $error("feedback pulse without edge");
	chk_bypass_modulus: assert property (B_BYPASS_OUT && $past(B_BYPASS_OUT) |-> !MODULUS_HIGH_OUT)
		else $error("high modulus during bypass");
	cov_r_pulse: cover property (R_DIV_OUT);
	cov_n_pulse: cover property (N_DIV_OUT);
	cov_parked: cover property (PUMP_MID_SUPPLY_OUT);
endmodule : pdc_top_asserts

bind pdc_top pdc_top_asserts u_chk (.REF_CLK_IN, .RESET_N_IN, .REG_RD_IN, .REG_RVALID_OUT, .REF_EDGE_IN,
	.PRESC_EDGE_IN, .PUMP_SOURCE_OUT, .PUMP_SINK_OUT, .PUMP_DRIVE_OUT, .PUMP_MID_SUPPLY_OUT,
	.PUMP_CURRENT_CODE_OUT, .PUMP_CURRENT_UA_OUT, .PD_ASYNC_OUT, .PD_SYNC_OUT, .R_DIV_OUT, .N_DIV_OUT,
	.MODULUS_HIGH_OUT, .B_BYPASS_OUT);

// ==== pdc_host.sv ====
// Host model driving the register port
`timescale 1ns/100ps
module pdc_host (
	// Clock and mode
	input  wire logic       clk_in,
	input  wire logic       ext_osc_in,
	// Register port
	input  wire logic [7:0] rdata_in,
	input  wire logic       rvalid_in,
	output logic            wr_out,
	output logic            rd_out,
	output logic [9:0]      addr_out,
	output logic [7:0]      wdata_out
);
	initial begin
		wr_out = 1'b0;
		rd_out = 1'b0;
		addr_out = 10'h000;
		wdata_out = 8'h00;
	end
	task automatic wr(input logic [9:0] a, input logic [7:0] d);
		@(posedge clk_in);
		wr_out <= 1'b1;
		addr_out <= a;
		wdata_out <= (a == 10'h010 && !ext_osc_in) ? (d & 8'h7F) : d;
		@(posedge clk_in);
		wr_out <= 1'b0;
		addr_out <= ~a;
		wdata_out <= ~d;
	endtask : wr
	task automatic rd(input logic [9:0] a, output logic [7:0] d);
		int n;
		@(posedge clk_in);
		rd_out <= 1'b1;
		addr_out <= a;
		@(posedge clk_in);
		rd_out <= 1'b0;
		addr_out <= ~a;
		#1;
		for (n = 0; n < 4 && rvalid_in !== 1'b1; n++) begin
			@(posedge clk_in);
			#1;
		end
		d = (rvalid_in === 1'b1) ? rdata_in : 8'hXX;
	endtask : rd
endmodule : pdc_host

// ==== pdc_top_tb.sv ====
// Self-checking bench for the loop divider control bank
`timescale 1ns/100ps
module pdc_top_tb;
	import pdc_pkg::*;
	logic REF_CLK_IN = 1'b0, RESET_N_IN = 1'b0, REG_WR_IN, REG_RD_IN, REG_RVALID_OUT;
	logic REF_EDGE_IN = 1'b0, PRESC_EDGE_IN = 1'b0, DET_UP_IN = 1'b1, DET_DN_IN = 1'b0;
	logic PUMP_SOURCE_OUT, PUMP_SINK_OUT, PUMP_DRIVE_OUT, PUMP_MID_SUPPLY_OUT, POLARITY_INV_OUT;
	logic PD_ASYNC_OUT, PD_SYNC_OUT, R_DIV_OUT, N_DIV_OUT, MODULUS_HIGH_OUT, B_BYPASS_OUT;
	logic [9:0]  REG_ADDR_IN;
	logic [7:0]  REG_WDATA_IN, REG_RDATA_OUT, d;
	logic [2:0]  PUMP_CURRENT_CODE_OUT, PRESC_SEL_OUT;
	logic [12:0] PUMP_CURRENT_UA_OUT;
	logic [2:0]  cc [4] = '{3'h2, 3'h3, 3'h4, 3'h6};
	logic [12:0] cu [4] = '{13'h0708, 13'h0960, 13'h0BB8, 13'h1068};
	int          error_cnt = 0, tests_run = 0, rc = 0, nc = 0, i;
	logic        cnt_clr = 1'b0;
	always #4 REF_CLK_IN = ~REF_CLK_IN;
	pdc_top dut (.REF_CLK_IN, .RESET_N_IN, .REG_WR_IN, .REG_RD_IN, .REG_ADDR_IN, .REG_WDATA_IN, .REG_RDATA_OUT,
		.REG_RVALID_OUT, .REF_EDGE_IN, .PRESC_EDGE_IN, .DET_UP_IN, .DET_DN_IN, .PUMP_SOURCE_OUT, .PUMP_SINK_OUT,
		.PUMP_DRIVE_OUT, .PUMP_MID_SUPPLY_OUT, .PUMP_CURRENT_CODE_OUT, .PUMP_CURRENT_UA_OUT, .POLARITY_INV_OUT,
		.PD_ASYNC_OUT, .PD_SYNC_OUT, .R_DIV_OUT, .N_DIV_OUT, .MODULUS_HIGH_OUT, .PRESC_SEL_OUT, .B_BYPASS_OUT);
	pdc_host host (.clk_in(REF_CLK_IN), .ext_osc_in(1'b1), .rdata_in(REG_RDATA_OUT), .rvalid_in(REG_RVALID_OUT),
		.wr_out(REG_WR_IN), .rd_out(REG_RD_IN), .addr_out(REG_ADDR_IN), .wdata_out(REG_WDATA_IN));
	always @(posedge REF_CLK_IN) begin
		rc <= cnt_clr ? 0 : rc + int'(R_DIV_OUT === 1'b1);
		nc <= cnt_clr ? 0 : nc + int'(N_DIV_OUT === 1'b1);
	end
	//////////////////////////////////////////////////////////////////////////
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		tests_run++;
		if (seen !== exp) begin
			error_cnt++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : check
	task automatic test_done;
		$display("checks=%0d errors=%0d", tests_run, error_cnt);
		if (error_cnt == 0 && tests_run > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask : test_done
	task automatic rchk(input logic [9:0] a, input logic [7:0] e);
		host.rd(a, d);
		check(16'(d), 16'(e));
	endtask : rchk
	// Buffer write then copy to active
	task automatic cfg(input logic [9:0] a, input logic [7:0] v);
		host.wr(a, v);
		host.wr(PDC_ADDR_UPDATE, 8'h01);
		repeat (3) @(posedge REF_CLK_IN);
		#1;
	endtask : cfg
	// Edge every other cycle, pulses counted until the last one lands
	task automatic edges(input int n);
		int k;
		// Counters cleared by their own process, one owner each
		@(posedge REF_CLK_IN);
		cnt_clr <= 1'b1;
		@(posedge REF_CLK_IN);
		cnt_clr <= 1'b0;
		for (k = 0; k < n; k++) begin
			@(posedge REF_CLK_IN);
			REF_EDGE_IN <= 1'b1;
			PRESC_EDGE_IN <= 1'b1;
			@(posedge REF_CLK_IN);
			REF_EDGE_IN <= 1'b0;
			PRESC_EDGE_IN <= 1'b0;
		end
		repeat (4) @(posedge REF_CLK_IN);
		#1;
	endtask : edges
	//////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (6) @(posedge REF_CLK_IN);
		RESET_N_IN <= 1'b1;
		rchk(PDC_ADDR_LOOP_PUMP, PDC_RST_LOOP_PUMP);
		rchk(PDC_ADDR_REF_LOW, 8'h01);
		rchk(PDC_ADDR_REF_HIGH, 8'h00);
		rchk(PDC_ADDR_A_COUNT, 8'h00);
		rchk(PDC_ADDR_B_LOW, 8'h03);
		rchk(PDC_ADDR_B_HIGH, 8'h00);
		rchk(10'h3FF, 8'h00);
		check(16'(PD_ASYNC_OUT), 16'h1);
		host.wr(PDC_ADDR_LOOP_PUMP, 8'hAE);
		host.wr(PDC_ADDR_READBACK_SEL, 8'h01);
		rchk(PDC_ADDR_LOOP_PUMP, PDC_RST_LOOP_PUMP);
		check(16'(POLARITY_INV_OUT), 16'h0);
		cfg(PDC_ADDR_UPDATE, 8'h01);
		rchk(PDC_ADDR_LOOP_PUMP, 8'hAE);
		check(16'(POLARITY_INV_OUT), 16'h1);
		host.wr(PDC_ADDR_READBACK_SEL, 8'h00);
		for (i = 0; i < 4; i++) begin
			cfg(PDC_ADDR_LOOP_PUMP, {1'b0, cc[i], 2'(i), 2'(i)});
			check(16'(PUMP_CURRENT_UA_OUT), 16'(cu[i]));
			check(16'(PUMP_CURRENT_CODE_OUT), 16'(cc[i]));
			check(16'(PUMP_DRIVE_OUT), 16'(i != 0));
			check(16'(PUMP_SOURCE_OUT), 16'(i == 1 || i == 3));
			check(16'(PUMP_SINK_OUT), 16'(i == 2));
			check(16'(PD_ASYNC_OUT), 16'(i == 1));
			check(16'(PD_SYNC_OUT), 16'(i == 3));
		end
		@(posedge REF_CLK_IN);
		DET_UP_IN <= 1'b0;
		DET_DN_IN <= 1'b1;
		cfg(PDC_ADDR_LOOP_PUMP, 8'hAC);
		check(16'({PUMP_SOURCE_OUT, PUMP_SINK_OUT}), 16'h2);
		cfg(PDC_ADDR_CNT_RESET, 8'h86);
		check(16'({PUMP_MID_SUPPLY_OUT, PUMP_DRIVE_OUT, PUMP_SOURCE_OUT}), 16'h4);
		host.wr(PDC_ADDR_REF_LOW, 8'h03);
		host.wr(PDC_ADDR_B_LOW, 8'h04);
		host.wr(PDC_ADDR_A_COUNT, 8'h02);
		rchk(PDC_ADDR_A_COUNT, 8'h02);
		cfg(PDC_ADDR_CNT_RESET, 8'h06);
		edges(12);
		check(16'(rc), 16'h4);
		check(16'(nc), 16'h3);
		check(16'(MODULUS_HIGH_OUT), 16'h1);
		edges(2);
		check(16'(MODULUS_HIGH_OUT), 16'h0);
		cfg(PDC_ADDR_CNT_RESET, 8'h46);
		edges(12);
		check(16'(rc), 16'h0);
		check(16'(nc), 16'h3);
		cfg(PDC_ADDR_CNT_RESET, 8'h06);
		edges(11);
		check(16'(rc), 16'h3);
		cfg(PDC_ADDR_CNT_RESET, 8'h26);
		edges(12);
		check(16'(rc), 16'h4);
		check(16'(nc), 16'h0);
		cfg(PDC_ADDR_CNT_RESET, 8'h16);
		edges(6);
		check(16'(rc + nc), 16'h0);
		cfg(PDC_ADDR_CNT_RESET, 8'h0F);
		edges(5);
		check(16'(nc), 16'h5);
		check(16'({B_BYPASS_OUT, PRESC_SEL_OUT}), 16'hF);
		check(16'(MODULUS_HIGH_OUT), 16'h0);
		host.wr(PDC_ADDR_REF_LOW, 8'h00);
		cfg(PDC_ADDR_REF_HIGH, 8'h01);
		edges(256);
		check(16'(rc), 16'h1);
		test_done();
	end
endmodule : pdc_top_tb
